// >>> rtl/spi_slave_pkg.sv
// shared constants and types for the serial slave block
package spi_slave_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // data and pin widths
  localparam int DATA_W        = 8;
  localparam int PIN_W         = 3;
  localparam int PIN_SCK       = 0;
  localparam int PIN_SEL       = 1;
  localparam int PIN_MOSI      = 2;
  localparam int RX_FIFO_DEPTH = 4;

  ////////////////////////////////////////////////////////////////////////////
  // sticky flag positions in the flag vector
  localparam int FLAG_W         = 4;
  localparam int FLAG_BYTE_DONE = 0;
  localparam int FLAG_COLLISION = 1;
  localparam int FLAG_RX_DONE   = 2;
  localparam int FLAG_TX_DONE   = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and bit counter limits
  localparam logic [PIN_W-1:0]  PIN_RESET   = 3'h2;  // select idles high
  localparam logic [DATA_W-1:0] SHIFT_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
  localparam logic [2:0]        BIT_FIRST   = 3'h0;
  localparam logic [2:0]        BIT_LAST    = 3'h7;
  localparam logic [2:0]        BIT_STEP    = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // slave sequencer states
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } slave_state_type;

endpackage

// >>> rtl/rx_fifo_if.sv
// handshake bundle between the receive path and its fifo
`timescale 1ns/1ns
interface rx_fifo_if #(parameter int WIDTH = 8);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport fifo_side (input push_valid, push_data, pop_ready,
                     output push_ready, pop_valid, pop_data);
  modport user_side (output push_valid, push_data, pop_ready,
                     input push_ready, pop_valid, pop_data);
endinterface // rx_fifo_if

// >>> rtl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
  parameter int           W         = 3,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // raw pins and filtered levels
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] level
);

  logic [W-1:0] q1;
  logic [W-1:0] q2;
  logic [W-1:0] q3;

  // q1 feeds only q2; a change counts once q2 and q3 agree
  always_ff @(posedge clk) begin
    if (rst) begin
      q1    <= RESET_VAL;
      q2    <= RESET_VAL;
      q3    <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      q1    <= pins;
      q2    <= q1;
      q3    <= q2;
      level <= (~(q2 ^ q3) & q3) | ((q2 ^ q3) & level);
    end
  end

endmodule // pin_sync

// >>> rtl/rx_fifo.sv
// small receive fifo, head always at entry zero
`timescale 1ns/1ns
module rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // both handshake sides
  rx_fifo_if.fifo_side port_b
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             do_push;
  logic             do_pop;

  assign do_push = port_b.push_valid && port_b.push_ready;
  assign do_pop  = port_b.pop_valid && port_b.pop_ready;
  assign port_b.pop_data = mem[0];

  // occupancy after this cycle
  always_comb begin
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = count + CW'(1);
    end else if (do_pop && !do_push) begin
      next_count = count - CW'(1);
    end
  end

  // ready and valid come from flops so full and empty are exact
  always_ff @(posedge clk) begin
    if (rst) begin
      count             <= '0;
      port_b.pop_valid  <= 1'b0;
      port_b.push_ready <= 1'b1;
    end else begin
      count             <= next_count;
      port_b.pop_valid  <= (next_count != '0);
      port_b.push_ready <= (next_count != CW'(DEPTH));
    end
  end

  // storage shifts toward the head on a pop; a push lands behind the last entry
  always_ff @(posedge clk) begin
    if (do_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem[i] <= mem[i+1];
      end
    end
    if (do_push) begin
      mem[int'(count) - int'(do_pop)] <= port_b.push_data;
    end
  end

endmodule // rx_fifo

// >>> rtl/spi_slave_select_and_buffering.sv
// serial slave with select handling, buffered modes and receive fifo
`timescale 1ns/1ns

// Overview of operation
// R1: host role with select as input and disable clear: low select makes us slave
// R2: select configured as output in host role has no effect on the block
// R3: after select drops the host role, it stays slave until software sets role again
// R4: outside master keeps each clock phase longer than two system clock cycles
// R5: normal slave idles while select is high; data writes allowed, clock ignored
// R6: after select falls, shifting starts with the first clock pulse
// R7: normal mode sets the byte-done flag after every full byte
// R8: normal mode write during a transfer is dropped and sets the collision flag
// R9: select high halts the slave and discards a partial byte
// R10: buffer mode enable adds holding buffer, extra receive buffering and flags; here the 4-entry receive fifo is used the same in both modes
// R11: buffered, wait bit 0: first transfer sends shift register content as dummy
// R12: wait bit 0: writes go to holding buffer, moved after the dummy transfer
// R13: buffered write with holding buffer full is lost, buffer unchanged
// R14: buffer-empty flag clears on buffer write, sets when buffer moves to shifter
// R15: buffered receive-complete flag sets one cycle after buffer-empty rises
// R16: transfer-complete sets one cycle after receive-complete when all data sent
// R17: wait bit 1: write while select high goes to shifter next cycle
// R18: wait bit 1 flag timing matches wait bit 0
// R19: select, mosi and clock are always inputs in slave mode
// R20: miso driven while select low, released while high, if set as output
// R21: select high resets the slave sequencer at once, abandoning the transfer
// R22: host software rechecks its role bit before each byte written
// R23: select rising mid-byte returns the bit counter to zero
module spi_slave_select_and_buffering (
  // clock and reset
  input  wire logic                               CLK,
  input  wire logic                               RST,
  // serial pins, sampled on CLK
  input  wire logic                               SCK_IN,
  input  wire logic                               SELECT_N_IN,
  input  wire logic                               MOSI_IN,
  output logic                                    MISO_OUT,
  output logic                                    MISO_OE,
  // configuration levels
  input  wire logic                               ENABLE,
  input  wire logic                               BUFFER_MODE_ENABLE,
  input  wire logic                               WAIT_FOR_RECEIVE_BIT,
  input  wire logic                               SELECT_PIN_DISABLE,
  input  wire logic                               SELECT_DIR_OUT,
  input  wire logic                               MISO_DIR_OUT,
  // host role bit access
  input  wire logic                               HOST_ROLE_WRITE,
  input  wire logic                               HOST_ROLE_VALUE,
  output logic                                    HOST_ROLE,
  // transmit data write
  input  wire logic                               DATA_WRITE,
  input  wire logic [spi_slave_pkg::DATA_W-1:0]   DATA_IN,
  // received data stream
  output logic                                    RX_VALID,
  output logic [spi_slave_pkg::DATA_W-1:0]        RX_DATA,
  input  wire logic                               RX_READY,
  output logic                                    RX_SPACE,
  // status flags and their clear strobes
  input  wire logic [spi_slave_pkg::FLAG_W-1:0]   FLAG_CLEAR,
  output logic                                    BYTE_DONE_FLAG,
  output logic                                    WRITE_COLLISION_FLAG,
  output logic                                    RX_COMPLETE_FLAG,
  output logic                                    TRANSFER_COMPLETE_FLAG,
  output logic                                    TX_BUFFER_EMPTY_FLAG
);
  import spi_slave_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [PIN_W-1:0]  pin_level;
  logic              sck_prev;
  logic              sck_rise;
  logic              sck_fall;
  logic              sel_low;
  logic              mosi;
  slave_state_type   state;
  slave_state_type   next_state;
  logic [2:0]        bit_cnt;
  logic [DATA_W-1:0] shifter;
  logic [DATA_W-1:0] hold_buf;
  logic              hold_full;
  logic [DATA_W-1:0] pend_data;
  logic              pend_valid;
  logic              shifter_loaded;
  logic              byte_end;
  logic              busy;
  logic              wr_normal;
  logic              wr_direct;
  logic              wr_hold;
  logic              copy_hold;
  logic              host_lost;
  logic              done_d1;
  logic              done_d2;
  logic              drained_d1;
  logic              drained_d2;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] flag_set;

  rx_fifo_if #(.WIDTH(DATA_W)) rx_bus ();

  // true when the shifter is exchanging bits with the outside master
  function automatic logic is_shifting(input slave_state_type st);
    return st == ST_SHIFT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling; clock phases must exceed two cycles to be seen   [R4]
  pin_sync #(
    .W         (PIN_W),
    .RESET_VAL (PIN_RESET)
  ) u_sync (
    .clk   (CLK),
    .rst   (RST),
    .pins  ({MOSI_IN, SELECT_N_IN, SCK_IN}),
    .level (pin_level)
  );

  // select, mosi and clock are only ever read, never driven   [R19]
  assign sel_low  = !pin_level[PIN_SEL];
  assign mosi     = pin_level[PIN_MOSI];
  assign sck_rise = pin_level[PIN_SCK] && !sck_prev;
  assign sck_fall = !pin_level[PIN_SCK] && sck_prev;

  // edge detector looks at the filtered level only
  always_ff @(posedge CLK) begin
    if (RST) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= pin_level[PIN_SCK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host role bit and fall back to slave on a low select
  // hardware clear wins over a same-cycle software write, so a lost bus is
  // never silently reclaimed
  assign host_lost = HOST_ROLE && ENABLE && !SELECT_PIN_DISABLE && !SELECT_DIR_OUT
                     && sel_low; // [R1] [R2]

  always_ff @(posedge CLK) begin
    if (RST) begin
      HOST_ROLE <= 1'b0;
    end else if (host_lost) begin
      HOST_ROLE <= 1'b0; // [R1]
    end else if (HOST_ROLE_WRITE) begin
      HOST_ROLE <= HOST_ROLE_VALUE; // only software sets it again [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave sequencer: select high drops straight back to idle   [R21]
  always_comb begin
    case (state)
      ST_OFF: begin
        next_state = (ENABLE && !HOST_ROLE) ? ST_IDLE : ST_OFF;
      end
      ST_IDLE: begin
        next_state = sel_low ? ST_SHIFT : ST_IDLE; // [R5]
      end
      ST_SHIFT: begin
        next_state = sel_low ? ST_SHIFT : ST_IDLE; // [R9] [R21]
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    if (!ENABLE || HOST_ROLE) begin
      next_state = ST_OFF;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit counter; a byte ends on the eighth sampling edge
  assign byte_end = is_shifting(state) && sck_rise && (bit_cnt == BIT_LAST);

  always_ff @(posedge CLK) begin
    if (RST) begin
      bit_cnt <= BIT_FIRST;
    end else if (!is_shifting(state)) begin
      bit_cnt <= BIT_FIRST; // resync with the master at every select [R23]
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + BIT_STEP; // first pulse after select falls [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data write steering
  assign busy      = is_shifting(state) && ((bit_cnt != BIT_FIRST) || sck_rise);
  assign wr_normal = DATA_WRITE && !BUFFER_MODE_ENABLE && !busy; // [R5]
  assign wr_direct = DATA_WRITE && BUFFER_MODE_ENABLE && WAIT_FOR_RECEIVE_BIT
                     && !sel_low && !shifter_loaded && !pend_valid; // [R17]
  assign wr_hold   = DATA_WRITE && BUFFER_MODE_ENABLE && !wr_direct
                     && !hold_full; // full buffer drops the byte [R13]
  assign copy_hold = byte_end && BUFFER_MODE_ENABLE && hold_full; // [R12]

  // a direct write reaches the shifter one cycle after it is made
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_valid <= 1'b0;
      pend_data  <= SHIFT_RESET;
    end else begin
      pend_valid <= wr_direct; // [R17]
      if (wr_direct) begin
        pend_data <= DATA_IN;
      end
    end
  end

  // wait bit 1: only the first write while deselected bypasses the buffer
  always_ff @(posedge CLK) begin
    if (RST) begin
      shifter_loaded <= 1'b0;
    end else if (!BUFFER_MODE_ENABLE || !WAIT_FOR_RECEIVE_BIT) begin
      shifter_loaded <= 1'b0;
    end else if (pend_valid) begin
      shifter_loaded <= 1'b1;
    end else if (byte_end && !hold_full) begin
      shifter_loaded <= 1'b0;
    end
  end

  // holding buffer; in normal mode it is never used   [R10]
  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_buf  <= SHIFT_RESET;
      hold_full <= 1'b0;
    end else if (!BUFFER_MODE_ENABLE) begin
      hold_full <= 1'b0;
    end else if (copy_hold) begin
      hold_full <= 1'b0; // moved into the shifter [R12]
    end else if (wr_hold) begin
      hold_buf  <= DATA_IN; // wait bit 0 sends all writes here [R12]
      hold_full <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register; until the buffer is copied its old content goes out,
  // which is the dummy byte of the first buffered transfer   [R11]
  always_ff @(posedge CLK) begin
    if (RST) begin
      shifter <= SHIFT_RESET;
    end else if (copy_hold) begin
      shifter <= hold_buf; // [R12]
    end else if (is_shifting(state) && sck_rise) begin
      shifter <= {shifter[DATA_W-2:0], mosi}; // [R6]
    end else if (pend_valid) begin
      shifter <= pend_data; // [R17]
    end else if (wr_normal) begin
      shifter <= DATA_IN; // idle write is allowed [R5] [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // miso: next bit presented on the falling edge, released when deselected
  always_ff @(posedge CLK) begin
    if (RST) begin
      MISO_OUT <= 1'b0;
      MISO_OE  <= 1'b0;
    end else begin
      MISO_OE <= is_shifting(next_state) && MISO_DIR_OUT; // [R20]
      if (!is_shifting(state) || sck_fall || (bit_cnt == BIT_FIRST && !sck_rise)) begin
        MISO_OUT <= shifter[DATA_W-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completed bytes enter the receive fifo; a full fifo drops the byte since
  // the outside master cannot be stalled, RX_SPACE warns software early
  assign rx_bus.push_valid = byte_end; // partial bytes never get here [R9]
  assign rx_bus.push_data  = {shifter[DATA_W-2:0], mosi};
  assign rx_bus.pop_ready  = RX_READY;
  assign RX_VALID          = rx_bus.pop_valid;
  assign RX_DATA           = rx_bus.pop_data;
  assign RX_SPACE          = rx_bus.push_ready;

  rx_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk    (CLK),
    .rst    (RST),
    .port_b (rx_bus.fifo_side)
  );

  ////////////////////////////////////////////////////////////////////////////
  // completion pipeline for the buffered flags
  always_ff @(posedge CLK) begin
    if (RST) begin
      done_d1    <= 1'b0;
      done_d2    <= 1'b0;
      drained_d1 <= 1'b0;
      drained_d2 <= 1'b0;
    end else begin
      done_d1    <= byte_end && BUFFER_MODE_ENABLE;
      done_d2    <= done_d1;
      drained_d1 <= !hold_full; // nothing left behind the shifter [R16]
      drained_d2 <= drained_d1;
    end
  end

  // buffer-empty level: low on a buffer write, high after the copy
  always_ff @(posedge CLK) begin
    if (RST) begin
      TX_BUFFER_EMPTY_FLAG <= 1'b1;
    end else if (!BUFFER_MODE_ENABLE || copy_hold) begin
      TX_BUFFER_EMPTY_FLAG <= 1'b1; // [R14]
    end else if (wr_hold) begin
      TX_BUFFER_EMPTY_FLAG <= 1'b0; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags; a set in the same cycle as its clear wins
  always_comb begin
    flag_set                 = FLAGS_RESET;
    flag_set[FLAG_BYTE_DONE] = (byte_end && !BUFFER_MODE_ENABLE) || host_lost; // [R7]
    flag_set[FLAG_COLLISION] = DATA_WRITE && !BUFFER_MODE_ENABLE && busy; // [R8]
    flag_set[FLAG_RX_DONE]   = done_d1; // one cycle after buffer-empty [R15] [R18]
    flag_set[FLAG_TX_DONE]   = done_d2 && drained_d2; // [R16] [R18]
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= flag_set | (flags & ~FLAG_CLEAR);
    end
  end

  assign BYTE_DONE_FLAG         = flags[FLAG_BYTE_DONE];
  assign WRITE_COLLISION_FLAG   = flags[FLAG_COLLISION];
  assign RX_COMPLETE_FLAG       = flags[FLAG_RX_DONE];
  assign TRANSFER_COMPLETE_FLAG = flags[FLAG_TX_DONE];

endmodule // spi_slave_select_and_buffering

// >>> dv/spi_slave_assertions.sv
// concurrent checks on the serial slave top-level ports
`timescale 1ns/1ns
module spi_slave_assertions (
  // clock, reset, pins and configuration
  input wire logic CLK, RST, SELECT_N_IN, ENABLE, BUFFER_MODE_ENABLE,
  input wire logic WAIT_FOR_RECEIVE_BIT, SELECT_PIN_DISABLE, SELECT_DIR_OUT, MISO_DIR_OUT,
  input wire logic HOST_ROLE_WRITE, DATA_WRITE,
  // watched outputs
  input wire logic MISO_OE, HOST_ROLE, RX_VALID, BYTE_DONE_FLAG, WRITE_COLLISION_FLAG,
  input wire logic RX_COMPLETE_FLAG, TRANSFER_COMPLETE_FLAG, TX_BUFFER_EMPTY_FLAG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // counts cover the pin synchroniser
  sequence fallback_held;
    (HOST_ROLE && ENABLE && !SELECT_N_IN && !SELECT_PIN_DISABLE && !SELECT_DIR_OUT
     && !HOST_ROLE_WRITE)[*6];
  endsequence
  sequence slave_selected;
    (!SELECT_N_IN && ENABLE && MISO_DIR_OUT && !HOST_ROLE)[*8];
  endsequence
  sequence txe_rise;
    $rose(TX_BUFFER_EMPTY_FLAG) && BUFFER_MODE_ENABLE && !SELECT_N_IN && !$past(RST);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // role, pin enable and flag relations
  AST_FALLBACK: assert property (fallback_held |=> !HOST_ROLE)
    else $error("host role kept with select low");
  AST_FALLBACK_FLAG: assert property ($fell(HOST_ROLE) && !$past(HOST_ROLE_WRITE)
    && !$past(RST) |-> BYTE_DONE_FLAG)
    else $error("fallback without flag");
  AST_ROLE_OUT: assert property (HOST_ROLE && !HOST_ROLE_WRITE
    && (SELECT_DIR_OUT || SELECT_PIN_DISABLE) |=> HOST_ROLE)
    else $error("host role lost with select ignored");
  AST_ROLE_HOLD: assert property (!HOST_ROLE && !HOST_ROLE_WRITE |=> !HOST_ROLE)
    else $error("host role set without write");
  AST_IDLE_QUIET: assert property (SELECT_N_IN[*8] |-> !$rose(RX_VALID)
    && !$rose(BYTE_DONE_FLAG))
    else $error("activity while deselected");
  AST_OE_OFF: assert property (SELECT_N_IN[*7] |-> !MISO_OE)
    else $error("miso driven while deselected");
  AST_OE_ON: assert property (slave_selected |-> MISO_OE)
    else $error("miso not driven while selected");
  AST_NO_COLLIDE_BUF: assert property (BUFFER_MODE_ENABLE[*2]
    |-> !$rose(WRITE_COLLISION_FLAG))
    else $error("collision flag in buffered mode");
  AST_TXE_CLEAR: assert property (DATA_WRITE && BUFFER_MODE_ENABLE && !WAIT_FOR_RECEIVE_BIT
    && TX_BUFFER_EMPTY_FLAG |=> !TX_BUFFER_EMPTY_FLAG)
    else $error("buffer empty flag not cleared");
  AST_RXC_STEP: assert property (txe_rise |=> RX_COMPLETE_FLAG)
    else $error("receive complete late");
  AST_TXC_STEP: assert property ($rose(TRANSFER_COMPLETE_FLAG) |-> $past(RX_COMPLETE_FLAG))
    else $error("transfer complete before receive complete");
endmodule // spi_slave_assertions

bind spi_slave_select_and_buffering spi_slave_assertions u_spi_slave_assertions (.*);

// >>> dv/spi_master_model.sv
// behavioural serial bus master driving clock, select and data
`timescale 1ns/1ns
module spi_master_model (
  // link pins
  output logic     sck,
  output logic     sel_n,
  output logic     mosi,
  input wire logic miso_line
);
  // idle: clock parked low, select high
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // select change with settle time
  task automatic sel(input logic lvl);
    #100 sel_n = lvl;
    #100;
  endtask

  // n bits msb first, mode 0; 62/63 ns phases stay above two system cycles
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      mosi = tx[i];
      #62 sck = 1'b1;
      rx[i] = miso_line;
      #63 sck = 1'b0;
    end
    #60;
    mosi = ~mosi; // no stale level
  endtask
endmodule // spi_master_model

// >>> dv/spi_slave_select_and_buffering_tb_top.sv
// self-checking bench for the serial slave block
`timescale 1ns/1ns
module spi_slave_select_and_buffering_tb_top;
  // clock, reset and design inputs
  logic       CLK = 1'b0;
  logic       RST = 1'b1;
  logic       ENABLE = 1'b1;
  logic       BUFFER_MODE_ENABLE = 1'b0;
  logic       WAIT_FOR_RECEIVE_BIT = 1'b0;
  logic       SELECT_PIN_DISABLE = 1'b0;
  logic       SELECT_DIR_OUT = 1'b0;
  logic       MISO_DIR_OUT = 1'b1;
  logic       HOST_ROLE_WRITE = 1'b0;
  logic       HOST_ROLE_VALUE = 1'b0;
  logic       DATA_WRITE = 1'b0;
  logic [7:0] DATA_IN = 8'h00;
  logic       RX_READY = 1'b0;
  logic [3:0] FLAG_CLEAR = 4'h0;
  // design outputs and link wires
  logic       MISO_OUT, MISO_OE, HOST_ROLE, RX_VALID, RX_SPACE, TX_BUFFER_EMPTY_FLAG;
  logic       BYTE_DONE_FLAG, WRITE_COLLISION_FLAG, RX_COMPLETE_FLAG, TRANSFER_COMPLETE_FLAG;
  logic [7:0] RX_DATA;
  logic       sck, sel_n, mosi;
  int         err_total = 0;
  int         n_tests = 0;
  int         cycles = 0;
  // pull-up holds the released miso line high
  wire logic  miso_line = MISO_OE ? MISO_OUT : 1'b1;

  always #4 CLK = ~CLK;

  spi_slave_select_and_buffering u_spi_slave_select_and_buffering (.*, .SCK_IN(sck),
    .SELECT_N_IN(sel_n), .MOSI_IN(mosi));
  spi_master_model u_spi_master_model (.sck, .sel_n, .mosi, .miso_line);

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // settle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge CLK);
    DATA_WRITE <= 1'b1;
    DATA_IN <= d;
    @(posedge CLK);
    DATA_WRITE <= 1'b0;
  endtask
  task automatic clr();
    @(posedge CLK);
    FLAG_CLEAR <= 4'hF;
    @(posedge CLK);
    FLAG_CLEAR <= 4'h0;
  endtask
  task automatic pop(input logic [7:0] exp);
    cyc(1);
    chk({7'h00, RX_VALID}, 8'h01);
    chk(RX_DATA, exp);
    @(posedge CLK);
    RX_READY <= 1'b1;
    @(posedge CLK);
    RX_READY <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chk({RX_SPACE, RX_VALID, TX_BUFFER_EMPTY_FLAG, HOST_ROLE, TRANSFER_COMPLETE_FLAG,
         RX_COMPLETE_FLAG, WRITE_COLLISION_FLAG, BYTE_DONE_FLAG}, 8'hA0);
    chk({7'h00, MISO_OE}, 8'h00);
  endtask
  // host role: select as output is ignored, as input it forces slave
  task automatic t_host();
    @(posedge CLK);
    SELECT_DIR_OUT <= 1'b1;
    HOST_ROLE_WRITE <= 1'b1;
    HOST_ROLE_VALUE <= 1'b1;
    @(posedge CLK);
    HOST_ROLE_WRITE <= 1'b0;
    u_spi_master_model.sel(1'b0);
    chk({7'h00, HOST_ROLE}, 8'h01);
    @(posedge CLK);
    SELECT_DIR_OUT <= 1'b0;
    SELECT_PIN_DISABLE <= 1'b1;
    cyc(8);
    chk({7'h00, HOST_ROLE}, 8'h01);
    @(posedge CLK);
    SELECT_PIN_DISABLE <= 1'b0;
    MISO_DIR_OUT <= 1'b0;
    cyc(8);
    chk({5'h00, HOST_ROLE, MISO_OE, BYTE_DONE_FLAG}, 8'h01);
    MISO_DIR_OUT <= 1'b1;
    u_spi_master_model.sel(1'b1);
    chk({7'h00, HOST_ROLE}, 8'h00);
    clr();
  endtask
  // normal mode: idle clocks, collision, abort mid-byte
  task automatic t_normal();
    logic [7:0] r;
    wr(8'hA5);
    u_spi_master_model.bits(8'hFF, 4, r);
    cyc(4);
    chk({7'h00, RX_VALID}, 8'h00);
    u_spi_master_model.sel(1'b0);
    chk({7'h00, MISO_OE}, 8'h01);
    fork
      u_spi_master_model.bits(8'h3C, 8, r);
      begin
        cyc(40);
        wr(8'h45);
      end
    join
    cyc(6);
    chk(r, 8'hA5);
    chk({6'h00, WRITE_COLLISION_FLAG, BYTE_DONE_FLAG}, 8'h03);
    u_spi_master_model.bits(8'h96, 8, r);
    chk(r, 8'h3C);
    u_spi_master_model.bits(8'hF0, 3, r);
    u_spi_master_model.sel(1'b1);
    chk({7'h00, MISO_OE}, 8'h00);
    wr(8'h81);
    u_spi_master_model.sel(1'b0);
    u_spi_master_model.bits(8'h5A, 8, r);
    u_spi_master_model.sel(1'b1);
    chk(r, 8'h81);
    pop(8'h3C);
    pop(8'h96);
    pop(8'h5A);
    clr();
  endtask
  // buffered, dummy first byte; fifo filled past full while nobody pops
  task automatic t_buf0();
    logic [7:0] r;
    @(posedge CLK);
    BUFFER_MODE_ENABLE <= 1'b1;
    wr(8'h43);
    cyc(1);
    chk({7'h00, TX_BUFFER_EMPTY_FLAG}, 8'h00);
    u_spi_master_model.sel(1'b0);
    u_spi_master_model.bits(8'h11, 8, r);
    cyc(6);
    chk(r, 8'h5A);
    chk({5'h00, TRANSFER_COMPLETE_FLAG, RX_COMPLETE_FLAG, TX_BUFFER_EMPTY_FLAG}, 8'h03);
    wr(8'h44);
    wr(8'h45);
    u_spi_master_model.bits(8'h22, 8, r);
    cyc(6);
    chk(r, 8'h43);
    chk({7'h00, TRANSFER_COMPLETE_FLAG}, 8'h00);
    u_spi_master_model.bits(8'h33, 8, r);
    cyc(6);
    chk(r, 8'h44);
    chk({7'h00, TRANSFER_COMPLETE_FLAG}, 8'h01);
    u_spi_master_model.bits(8'h44, 8, r);
    u_spi_master_model.bits(8'h55, 8, r);
    chk({7'h00, RX_SPACE}, 8'h00);
    u_spi_master_model.sel(1'b1);
    for (int i = 1; i < 5; i++) begin
      pop({i[3:0], i[3:0]});
    end
    cyc(1);
    chk({7'h00, RX_VALID}, 8'h00);
    clr();
  endtask
  // buffered, wait bit set: first write goes straight to the shifter
  task automatic t_buf1();
    logic [7:0] r;
    @(posedge CLK);
    WAIT_FOR_RECEIVE_BIT <= 1'b1;
    wr(8'h61);
    cyc(3);
    wr(8'h62);
    u_spi_master_model.sel(1'b0);
    u_spi_master_model.bits(8'hA1, 8, r);
    cyc(6);
    chk(r, 8'h61);
    chk({5'h00, TRANSFER_COMPLETE_FLAG, RX_COMPLETE_FLAG, TX_BUFFER_EMPTY_FLAG}, 8'h03);
    u_spi_master_model.bits(8'hA2, 8, r);
    cyc(6);
    chk(r, 8'h62);
    chk({7'h00, TRANSFER_COMPLETE_FLAG}, 8'h01);
    @(posedge CLK);
    ENABLE <= 1'b0;
    u_spi_master_model.bits(8'h77, 8, r);
    u_spi_master_model.sel(1'b1);
    pop(8'hA1);
    pop(8'hA2);
    cyc(1);
    chk({7'h00, RX_VALID}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    cyc(4);
    t_reset();
    t_host();
    t_normal();
    t_buf0();
    t_buf1();
    final_report();
  end
endmodule // spi_slave_select_and_buffering_tb_top
